//--- core/acc_pkg.sv
package acc_pkg;

  // Register byte offsets on the Wishbone bus
  localparam logic [3:0] ADDR_CONTROL_0 = 4'h0;
  localparam logic [3:0] ADDR_CONTROL_1 = 4'h4;
  localparam logic [3:0] ADDR_PIN_ENABLE = 4'h8;
  localparam logic [3:0] ADDR_RESULT_LOW = 4'hC;
  localparam logic [5:0] ADDR_RESULT_HIGH = 6'h10;

  // Field positions in converter_control_0
  localparam int CTL0_START_BIT = 7;
  localparam int CTL0_BUSY_BIT = 6;
  localparam int CTL0_POWER_DOWN_BIT = 5;
  localparam int CTL0_ALIGN_BIT = 4;

  // Field positions in converter_control_1
  localparam int CTL1_INT_REF_BIT = 7;
  localparam int CTL1_BANDGAP_EN_BIT = 6;
  localparam int CTL1_REF_SEL_BIT = 4;
  localparam int CTL1_INT_ENABLE_BIT = 3;

  // Field position in the interrupt status register
  localparam int IRQ_REQUEST_BIT = 0;
  localparam logic [5:0] ADDR_IRQ_STATUS = 6'h14;

  // Reset values
  localparam logic [3:0] PIN_ENABLE_RESET = 4'hF;
  localparam logic [2:0] CLK_DIV_RESET = 3'h0;

  // Divider codes
  localparam logic [2:0] CLK_DIV_UNDEFINED = 3'h7;

  // Conversion length in converter clock periods
  localparam logic [4:0] CONV_PERIODS = 5'h10;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_HOLD = 3'b010,
    ACC_CONV = 3'b100
  } acc_phase_type;

  typedef struct packed {
    logic [11:0] sample;
    logic sample_valid;
  } acc_sample_type;

  typedef struct packed {
    logic [3:0] pin_analog;
    logic [1:0] channel;
    logic internal_ref;
    logic bandgap_en;
    logic ref_external;
    logic power_down;
    logic conv_reset;
    logic conv_sample;
  } acc_analog_type;

endpackage

//--- core/acc_conversion_control.sv
// Notes on behaviour
// - Pin-enable bit one selects analog function, zero leaves the pin's digital function.
// - Pin-enable bits 7 to 4 read zero and ignore writes.
// - Enable bit n routes port A pin n to analog channel n.
// - Start bit written low-high-low begins exactly one conversion.
// - Start held high keeps converter in reset and busy flag at one.
// - Hardware clears the busy flag at the end of each conversion.
// - Conversion end sets interrupt request; enabled request drives interrupt output.
// - Divider code 000 to 110 gives divide by 1 to 64; 111 undefined.
// - Power-down zero powers the converter; one switches it off.
// - Reference select zero uses supply pin, one the external reference pin.
// - Reference select one takes the shared pin over for the reference.
// - Channel field picks channel 0 to 3; internal-reference select overrides all.
// - Alignment zero left-aligns the 12-bit result, one right-aligns; unused bits zero.
// - A conversion takes sixteen converter clock periods.
// - Analog pins lose pull-high and ignore the port direction setting.
`timescale 1ns/1ps
`default_nettype none

module acc_conversion_control #(
  parameter int RESULT_WIDTH = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [RESULT_WIDTH-1:0] conv_data_i,
  output acc_pkg::acc_analog_type analog_o,
  output logic [3:0] pin_pull_high_disable_o,
  output logic [3:0] pin_direction_override_o,
  output logic ref_pin_takeover_o,
  output logic converter_clock_o,
  output logic irq_o
);

  typedef struct packed {
    // Sequencing and software-visible control fields
    acc_pkg::acc_phase_type phase;
    logic start;
    logic busy;
    logic power_down;
    logic align_right;
    logic [1:0] channel;
    logic internal_ref;
    logic bandgap_en;
    logic ref_external;
    logic int_enable;
    logic [2:0] clk_div;
    logic [3:0] pin_enable;
    // Divider and conversion progress
    logic [5:0] div_count;
    logic conv_clk;
    logic [4:0] periods;
    logic irq_request;
    logic [RESULT_WIDTH-1:0] result;
    // Bus answer
    logic [31:0] rdata;
    logic ack;
    // Registered outputs
    acc_pkg::acc_analog_type analog;
    logic [3:0] pull_dis;
    logic ref_take;
    logic irq;
  } acc_state_type;

  acc_state_type st_r;
  acc_state_type st_nxt;

  logic bus_req;
  logic wr_ctl0;
  logic wr_ctl1;
  logic wr_pins;
  logic wr_irq;
  logic [6:0] div_ratio;
  logic tick;
  logic conv_done;
  logic [15:0] result_left;
  logic [15:0] result_right;
  logic [15:0] result_view;

  // A request is taken only while ack is low, so each access is answered once
  assign bus_req = wb_cyc_i && wb_stb_i && !st_r.ack;
  assign wr_ctl0 = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == {2'h0, acc_pkg::ADDR_CONTROL_0};
  assign wr_ctl1 = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == {2'h0, acc_pkg::ADDR_CONTROL_1};
  assign wr_pins = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == {2'h0, acc_pkg::ADDR_PIN_ENABLE};
  assign wr_irq = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == acc_pkg::ADDR_IRQ_STATUS;

  // Undefined code 111 is treated as the slowest ratio so the counter stays bounded
  always_comb begin
    div_ratio = 7'h40;
    unique case (st_r.clk_div)
      3'h0: begin
        div_ratio = 7'h01;
      end
      3'h1: begin
        div_ratio = 7'h02;
      end
      3'h2: begin
        div_ratio = 7'h04;
      end
      3'h3: begin
        div_ratio = 7'h08;
      end
      3'h4: begin
        div_ratio = 7'h10;
      end
      3'h5: begin
        div_ratio = 7'h20;
      end
      3'h6: begin
        div_ratio = 7'h40;
      end
      acc_pkg::CLK_DIV_UNDEFINED: begin
        div_ratio = 7'h40;
      end
    endcase
  end

  // One tick per converter clock period, at the end of the period
  assign tick = ({1'b0, st_r.div_count} == div_ratio - 7'h01);

  assign result_left = {st_r.result, 4'h0};
  assign result_right = {4'h0, st_r.result};
  assign result_view = st_r.align_right ? result_right : result_left;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = bus_req;
    conv_done = 1'b0;

    // Divider runs freely only while powered, so a powered-down block is quiet
    if (st_r.power_down || tick) begin
      st_nxt.div_count = 6'h00;
    end else begin
      st_nxt.div_count = st_r.div_count + 6'h01;
    end
    // At divide-by-one a registered pin can only show half rate; tick still fires each cycle
    if (st_r.power_down) begin
      st_nxt.conv_clk = 1'b0;
    end else if (st_r.clk_div == 3'h0) begin
      st_nxt.conv_clk = ~st_r.conv_clk;
    end else begin
      st_nxt.conv_clk = {1'b0, st_r.div_count} < (div_ratio >> 1);
    end

    if (wr_ctl0) begin
      st_nxt.start = wb_dat_i[acc_pkg::CTL0_START_BIT];
      st_nxt.power_down = wb_dat_i[acc_pkg::CTL0_POWER_DOWN_BIT];
      st_nxt.align_right = wb_dat_i[acc_pkg::CTL0_ALIGN_BIT];
      st_nxt.channel = wb_dat_i[1:0];
    end
    if (wr_ctl1) begin
      st_nxt.internal_ref = wb_dat_i[acc_pkg::CTL1_INT_REF_BIT];
      st_nxt.bandgap_en = wb_dat_i[acc_pkg::CTL1_BANDGAP_EN_BIT];
      st_nxt.ref_external = wb_dat_i[acc_pkg::CTL1_REF_SEL_BIT];
      st_nxt.int_enable = wb_dat_i[acc_pkg::CTL1_INT_ENABLE_BIT];
      st_nxt.clk_div = wb_dat_i[2:0];
    end
    if (wr_pins) begin
      st_nxt.pin_enable = wb_dat_i[3:0];
    end

    // Start is compared with its own register, so writing one again does not restart
    unique case (st_r.phase)
      acc_pkg::ACC_IDLE: begin
        if (st_nxt.start && !st_r.start) begin
          st_nxt.phase = acc_pkg::ACC_HOLD;
          st_nxt.busy = 1'b1;
        end
      end
      acc_pkg::ACC_HOLD: begin
        // Converter stays in reset until start returns low
        st_nxt.busy = 1'b1;
        if (!st_nxt.start) begin
          st_nxt.phase = acc_pkg::ACC_CONV;
          st_nxt.periods = 5'h00;
          // Restart the divider so the first converter period is a whole one
          st_nxt.div_count = 6'h00;
        end
      end
      acc_pkg::ACC_CONV: begin
        if (st_nxt.start && !st_r.start) begin
          st_nxt.phase = acc_pkg::ACC_HOLD;
          st_nxt.busy = 1'b1;
        end else if (st_r.power_down) begin
          // Power-down aborts silently; busy stays set until a conversion completes
          st_nxt.phase = acc_pkg::ACC_IDLE;
        end else if (tick) begin
          st_nxt.periods = st_r.periods + 5'h01;
          if (st_r.periods + 5'h01 == acc_pkg::CONV_PERIODS) begin
            // Result, busy and request all change at this one edge
            st_nxt.phase = acc_pkg::ACC_IDLE;
            st_nxt.busy = 1'b0;
            st_nxt.result = conv_data_i;
            st_nxt.irq_request = 1'b1;
            conv_done = 1'b1;
          end
        end
      end
      default: begin
        st_nxt.phase = acc_pkg::ACC_IDLE;
      end
    endcase

    // Writing one clears the request; a completion in the same cycle wins
    if (wr_irq && wb_dat_i[acc_pkg::IRQ_REQUEST_BIT] && !conv_done) begin
      st_nxt.irq_request = 1'b0;
    end
    st_nxt.irq = st_nxt.irq_request && st_nxt.int_enable;

    // Outputs follow the next state, so pins see a write at the edge that raises ack
    st_nxt.analog.pin_analog = st_nxt.pin_enable;
    st_nxt.analog.channel = st_nxt.channel;
    st_nxt.analog.internal_ref = st_nxt.internal_ref;
    st_nxt.analog.bandgap_en = st_nxt.bandgap_en;
    st_nxt.analog.ref_external = st_nxt.ref_external;
    st_nxt.analog.power_down = st_nxt.power_down;
    st_nxt.analog.conv_reset = (st_nxt.phase == acc_pkg::ACC_HOLD);
    st_nxt.analog.conv_sample = (st_nxt.phase == acc_pkg::ACC_CONV);
    st_nxt.pull_dis = st_nxt.pin_enable;
    st_nxt.ref_take = st_nxt.ref_external;

    st_nxt.rdata = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        {2'h0, acc_pkg::ADDR_CONTROL_0}: begin
          st_nxt.rdata[acc_pkg::CTL0_START_BIT] = st_r.start;
          st_nxt.rdata[acc_pkg::CTL0_BUSY_BIT] = st_r.busy;
          st_nxt.rdata[acc_pkg::CTL0_POWER_DOWN_BIT] = st_r.power_down;
          st_nxt.rdata[acc_pkg::CTL0_ALIGN_BIT] = st_r.align_right;
          st_nxt.rdata[1:0] = st_r.channel;
        end
        {2'h0, acc_pkg::ADDR_CONTROL_1}: begin
          st_nxt.rdata[acc_pkg::CTL1_INT_REF_BIT] = st_r.internal_ref;
          st_nxt.rdata[acc_pkg::CTL1_BANDGAP_EN_BIT] = st_r.bandgap_en;
          st_nxt.rdata[acc_pkg::CTL1_REF_SEL_BIT] = st_r.ref_external;
          st_nxt.rdata[acc_pkg::CTL1_INT_ENABLE_BIT] = st_r.int_enable;
          st_nxt.rdata[2:0] = st_r.clk_div;
        end
        {2'h0, acc_pkg::ADDR_PIN_ENABLE}: begin
          st_nxt.rdata[7:0] = {4'h0, st_r.pin_enable};
        end
        {2'h0, acc_pkg::ADDR_RESULT_LOW}: begin
          st_nxt.rdata[7:0] = result_view[7:0];
        end
        acc_pkg::ADDR_RESULT_HIGH: begin
          st_nxt.rdata[7:0] = result_view[15:8];
        end
        acc_pkg::ADDR_IRQ_STATUS: begin
          st_nxt.rdata[7:0] = {7'h00, st_r.irq_request};
        end
        default: begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.phase <= acc_pkg::ACC_IDLE;
      // Busy reads set until the first conversion completes
      st_r.busy <= 1'b1;
      st_r.power_down <= 1'b1;
      st_r.pin_enable <= acc_pkg::PIN_ENABLE_RESET;
      st_r.clk_div <= acc_pkg::CLK_DIV_RESET;
      st_r.analog.pin_analog <= acc_pkg::PIN_ENABLE_RESET;
      st_r.analog.power_down <= 1'b1;
      st_r.pull_dis <= acc_pkg::PIN_ENABLE_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_dat_o = st_r.rdata;
  assign wb_ack_o = st_r.ack;
  assign analog_o = st_r.analog;
  assign pin_pull_high_disable_o = st_r.pull_dis;
  assign pin_direction_override_o = st_r.pull_dis;
  assign ref_pin_takeover_o = st_r.ref_take;
  assign converter_clock_o = st_r.conv_clk;
  assign irq_o = st_r.irq;

endmodule // acc_conversion_control

`default_nettype wire

//--- verification/acc_conversion_control_props.sv
`timescale 1ns/1ps
`default_nettype none
module acc_conversion_control_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire acc_pkg::acc_analog_type analog_o,
  input wire logic [3:0] pin_pull_high_disable_o,
  input wire logic [3:0] pin_direction_override_o,
  input wire logic ref_pin_takeover_o,
  input wire logic converter_clock_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  pin_rsvd_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == acc_pkg::ADDR_PIN_ENABLE
    |-> wb_dat_o[31:4] == 28'h0) else $error("pin enable upper bits set");
  pull_high_a: assert property (pin_pull_high_disable_o == analog_o.pin_analog)
    else $error("pull-high mismatch");
  dir_override_a: assert property (pin_direction_override_o == analog_o.pin_analog)
    else $error("direction override mismatch");
  ref_takeover_a: assert property (ref_pin_takeover_o == analog_o.ref_external)
    else $error("reference pin mismatch");
  pd_clock_a: assert property (analog_o.power_down [*2] |-> !converter_clock_o)
    else $error("clock runs while powered down");
  reset_value_a: assert property ($past(rst) |-> analog_o.pin_analog == 4'hF
    && analog_o.power_down) else $error("bad reset value");
  start_hold_a: assert property (analog_o.conv_reset |-> !analog_o.conv_sample)
    else $error("converting while held in reset");
  conv_min_a: assert property ($rose(analog_o.conv_sample) |-> analog_o.conv_sample [*8])
    else $error("conversion too short");
endmodule // acc_conversion_control_props
bind acc_conversion_control acc_conversion_control_props u_props (.clk, .rst, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .analog_o, .pin_pull_high_disable_o,
  .pin_direction_override_o, .ref_pin_takeover_o, .converter_clock_o);
`default_nettype wire

//--- verification/acc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_core_model #(
  parameter logic [11:0] SAMPLE = 12'hABC
) (
  input wire logic clk,
  input wire logic rst,
  input wire acc_pkg::acc_analog_type analog_i,
  output logic [11:0] data_o
);
  // Result is valid only while converting; lines toggle otherwise so a stray sample shows
  always_ff @(posedge clk) begin
    if (rst) data_o <= 12'h000;
    else data_o <= (analog_i.conv_sample && !analog_i.power_down) ? SAMPLE : ~data_o;
  end
endmodule // acc_core_model
`default_nettype wire

//--- verification/acc_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acc_conversion_control_tb;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, rpt, cko, irq;
  logic [5:0] adr = 6'h00;
  logic [3:0] sel = 4'hF, pph, pdo;
  logic [31:0] wdat = 32'h0, dout, rdat;
  logic [11:0] cdat;
  acc_pkg::acc_analog_type ana;
  int errors = 0, n_compared = 0, hi = 0;
  localparam int SETTLE_CYCLES = 50;
  initial forever #10 clk = ~clk;
  always @(posedge clk) hi <= ana.conv_sample ? hi + 1 : 0;
  acc_conversion_control u_dut (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .conv_data_i(cdat), .analog_o(ana), .pin_pull_high_disable_o(pph),
    .pin_direction_override_o(pdo), .ref_pin_takeover_o(rpt), .converter_clock_o(cko),
    .irq_o(irq));
  acc_core_model u_core (.clk, .rst, .analog_i(ana), .data_o(cdat));
  task stop_test;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wb(input logic w, input logic [5:0] a, input logic [31:0] v);
    int i;
    i = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= v;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (ack !== 1'b1) begin
      errors++;
      stop_test;
    end
    rdat = dout;
    cyc <= 0;
    stb <= 0;
    @(posedge clk);
  endtask
  task rc(input logic [5:0] a, input logic [31:0] exp, input string nm);
    wb(0, a, 32'h0);
    chk(nm, exp, rdat);
  endtask
  task clk_period(input logic [2:0] dv, input int exp);
    int n;
    int t0;
    logic prv;
    n = 0;
    t0 = 0;
    wb(1, acc_pkg::ADDR_CONTROL_1, {29'h0, dv});
    prv = cko;
    while (n < 400) begin
      @(posedge clk);
      n++;
      if (cko === 1'b1 && prv === 1'b0) begin
        if (t0 != 0) break;
        t0 = n;
      end
      prv = cko;
    end
    if (n >= 400) begin
      errors++;
      stop_test;
    end
    chk("clk_period", exp, n - t0);
  endtask
  task conv(input logic [2:0] dv, input logic ie);
    int n;
    wb(1, acc_pkg::ADDR_CONTROL_1, {28'h0, ie, dv});
    wb(1, acc_pkg::ADDR_CONTROL_0, {24'h0, 3'b100, dv[0], 4'h0});
    rc(acc_pkg::ADDR_CONTROL_0, {24'h0, 3'b110, dv[0], 4'h0}, "busy_hold");
    chk("conv_reset", 1, ana.conv_reset);
    wb(1, acc_pkg::ADDR_CONTROL_0, {24'h0, 3'b000, dv[0], 4'h0});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ana.conv_sample !== 1'b0 && n < 2000);
    if (n == 2000) begin
      errors++;
      stop_test;
    end
    chk("conv_len", 1, hi >= (16 << dv) && hi <= (16 << dv) + 2);
    n = 0;
    do begin
      wb(0, acc_pkg::ADDR_CONTROL_0, 32'h0);
      n++;
    end while (rdat[6] !== 1'b0 && n < 20);
    chk("busy_clear", 0, rdat[6]);
    chk("irq", ie, irq);
    rc(acc_pkg::ADDR_RESULT_HIGH, dv[0] ? 32'h0A : 32'hAB, "res_high");
    rc(acc_pkg::ADDR_RESULT_LOW, dv[0] ? 32'hBC : 32'hC0, "res_low");
    rc(acc_pkg::ADDR_IRQ_STATUS, 32'h1, "irq_request");
    wb(1, acc_pkg::ADDR_IRQ_STATUS, 32'h1);
    @(posedge clk);
    chk("irq_clear", 0, irq);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rc(acc_pkg::ADDR_PIN_ENABLE, 32'h0F, "pin_en_reset");
    rc(acc_pkg::ADDR_CONTROL_0, 32'h60, "ctl0_reset");
    rc(acc_pkg::ADDR_CONTROL_1, 32'h00, "ctl1_reset");
    wb(1, acc_pkg::ADDR_PIN_ENABLE, 32'hA5);
    rc(acc_pkg::ADDR_PIN_ENABLE, 32'h05, "pin_en_write");
    chk("pin_analog", 4'h5, ana.pin_analog);
    chk("pull_disable", 4'h5, pph);
    chk("dir_override", 4'h5, pdo);
    sel <= 4'h0;
    wb(1, acc_pkg::ADDR_PIN_ENABLE, 32'h0A);
    sel <= 4'hF;
    rc(acc_pkg::ADDR_PIN_ENABLE, 32'h05, "pin_en_nosel");
    rc(6'h18, 32'h0, "unmapped");
    wb(1, acc_pkg::ADDR_CONTROL_1, 32'h10);
    chk("ref_takeover", 1, rpt);
    chk("ref_external", 1, ana.ref_external);
    for (int c = 0; c < 4; c++) begin
      wb(1, acc_pkg::ADDR_CONTROL_0, c);
      chk("channel", c, ana.channel);
      chk("power_on", 0, ana.power_down);
    end
    wb(1, acc_pkg::ADDR_CONTROL_1, 32'h80);
    chk("internal_ref", 1, ana.internal_ref);
    chk("ref_release", 0, rpt);
    for (int d = 1; d < 8; d++) clk_period(d, (d == 7) ? 64 : (1 << d));
    repeat (SETTLE_CYCLES) @(posedge clk);
    // Only codes 5 and 6 give a legal converter period at this system clock
    conv(3'h5, 1'b1);
    conv(3'h6, 1'b0);
    wb(1, acc_pkg::ADDR_CONTROL_0, 32'h20);
    chk("power_off", 1, ana.power_down);
    chk("clock_stopped", 0, cko);
    stop_test;
  end
endmodule // acc_conversion_control_tb
`default_nettype wire
